/* src/hbsc_serial_ctrl.sv */
// Serial control and status interface of a triple half-bridge driver.
// Assumes chip select, serial clock, data and detector levels arrive asynchronously;
// the power stage takes a control word whenever apply_ready is high.
`timescale 1ns/10ps
module hbsc_serial_ctrl (
  // Clock, reset and freeze
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              mclk_en,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sclk,
  input  wire logic              serial_in,
  output logic                   sdo_out,
  output logic                   sdo_oe,
  // Standby pin and detector levels
  input  wire logic              standby_ctrl_n,
  input  wire hbsc_pkg::hbsc_sense_t sense,
  // Power stage handshake
  input  wire logic              apply_ready,
  output logic                   ctrl_buf_ready,
  // Switch drive
  output logic                   low_side_en_1,
  output logic                   high_side_en_1,
  output logic                   low_side_en_2,
  output logic                   high_side_en_2,
  output logic                   low_side_en_3,
  output logic                   high_side_en_3,
  output logic                   overcurrent_shutdown_en
);

  localparam int W = hbsc_pkg::WORD_W;
  localparam int N = hbsc_pkg::NUM_SW;

  // Synchroniser: first stage feeds only the second
  hbsc_pkg::hbsc_pins_t pins_raw;
  hbsc_pkg::hbsc_pins_t sync1_ff;
  hbsc_pkg::hbsc_pins_t sync2_ff;

  assign pins_raw = '{cs_n: cs_n, sclk: sclk, serial_in: serial_in,
                      standby_ctrl_n: standby_ctrl_n, sense: sense};

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_ff <= hbsc_pkg::PINS_RST;
      sync2_ff <= hbsc_pkg::PINS_RST;
    end
    else if (mclk_en)
    begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  // Edge detection on the synchronised link pins
  logic cs_prev_ff;
  logic sclk_prev_ff;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cs_prev_ff   <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end
    else if (mclk_en)
    begin
      cs_prev_ff   <= sync2_ff.cs_n;
      sclk_prev_ff <= sync2_ff.sclk;
    end
  end

  wire sel       = ~sync2_ff.cs_n;
  wire cs_fall   = cs_prev_ff & ~sync2_ff.cs_n;
  wire cs_rise   = ~cs_prev_ff & sync2_ff.cs_n;
  wire sclk_fall = sclk_prev_ff & ~sync2_ff.sclk;
  wire sclk_rise = ~sclk_prev_ff & sync2_ff.sclk;
  wire stby_on   = ~sync2_ff.standby_ctrl_n;
  // Standby acts as a held internal reset of control and status
  wire int_rst   = reset | stby_on;

  hbsc_pkg::hbsc_sense_t sns;
  assign sns = sync2_ff.sense;

  // Receive shift register and bit count
  logic [W-1:0] rx_sr_ff;
  logic [4:0]   rx_cnt_ff;
  logic [W-1:0] nxt_rx_sr;
  logic [4:0]   nxt_rx_cnt;

  wire rx_full = (rx_cnt_ff == hbsc_pkg::WORD_BITS);
  // LSB enters first and ends at bit zero
  assign nxt_rx_sr  = (sclk_fall & sel) ? {sync2_ff.serial_in, rx_sr_ff[W-1:1]} : rx_sr_ff;
  assign nxt_rx_cnt = cs_fall ? hbsc_pkg::CNT_ZERO :
                      (sclk_fall & sel & ~rx_full) ? rx_cnt_ff + hbsc_pkg::CNT_ONE :
                      rx_cnt_ff;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rx_sr_ff  <= hbsc_pkg::WORD_ZERO;
      rx_cnt_ff <= hbsc_pkg::CNT_ZERO;
    end
    else if (mclk_en)
    begin
      rx_sr_ff  <= nxt_rx_sr;
      rx_cnt_ff <= nxt_rx_cnt;
    end
  end

  wire commit = cs_rise & rx_full;

  // Pending word waits here when the buffer is full, so one frame during a stall is not lost;
  // a further frame while still blocked replaces it (newest setting wins).
  logic         pend_ff;
  logic [W-1:0] pend_word_ff;
  logic         buf_in_ready;
  logic         buf_out_valid;
  logic [W-1:0] buf_out_data;

  assign ctrl_buf_ready = buf_in_ready;

  always_ff @(posedge mclk)
  begin
    if (int_rst)
    begin
      pend_ff      <= 1'b0;
      pend_word_ff <= hbsc_pkg::WORD_ZERO;
    end
    else if (mclk_en)
    begin
      if (commit)
      begin
        pend_ff      <= 1'b1;
        pend_word_ff <= rx_sr_ff;
      end
      else if (buf_in_ready)
        pend_ff <= 1'b0;
    end
  end

  hbsc_word_buf #(
    .W     (W),
    .DEPTH (hbsc_pkg::BUF_DEPTH)
  ) u_word_buf (
    .mclk      (mclk),
    .reset     (int_rst),
    .mclk_en   (mclk_en),
    .in_valid  (pend_ff),
    .in_ready  (buf_in_ready),
    .in_data   (pend_word_ff),
    .out_valid (buf_out_valid),
    .out_ready (apply_ready),
    .out_data  (buf_out_data)
  );

  // Applied control word
  wire pop = buf_out_valid & apply_ready;
  hbsc_pkg::hbsc_ctrl_t ctrl_ff;
  hbsc_pkg::hbsc_ctrl_t nxt_ctrl;
  assign nxt_ctrl = '{shdn_en: buf_out_data[hbsc_pkg::CTRL_SHDN_BIT],
                      sw_en:   buf_out_data[hbsc_pkg::CTRL_SW_LSB +: N]};
  wire clr = pop & buf_out_data[hbsc_pkg::CTRL_CLR_BIT];

  always_ff @(posedge mclk)
  begin
    if (int_rst)
      ctrl_ff <= '{shdn_en: hbsc_pkg::SHDN_RST, sw_en: hbsc_pkg::SW_RST};
    else if (mclk_en && pop)
      ctrl_ff <= nxt_ctrl;
  end

  // Protection and flags
  logic [N-1:0] shut_ff;
  logic [N-1:0] sw_drive_ff;
  logic         short_flag_ff;
  logic         open_load_flag_ff;
  logic         supply_fail_flag_ff;

  wire [N-1:0] sw_cmd   = ctrl_ff.sw_en & ~shut_ff;
  wire [N-1:0] oc_trip  = sns.overcurrent & sw_cmd & {N{ctrl_ff.shdn_en}};
  wire [N-1:0] nxt_shut = (shut_ff & ~{N{clr}}) | oc_trip;
  wire [N-1:0] nxt_drv  = sw_cmd & ~oc_trip & {N{~sns.undervolt}};
  wire short_set  = |(sns.overcurrent & sw_cmd);
  wire open_set   = |(sns.open_load & sw_drive_ff);
  wire supply_set = sns.undervolt;

  always_ff @(posedge mclk)
  begin
    if (int_rst)
    begin
      shut_ff             <= '0;
      sw_drive_ff         <= '0;
      short_flag_ff       <= 1'b0;
      open_load_flag_ff   <= 1'b0;
      supply_fail_flag_ff <= 1'b0;
    end
    else if (mclk_en)
    begin
      shut_ff             <= nxt_shut;
      sw_drive_ff         <= nxt_drv;
      short_flag_ff       <= (short_flag_ff & ~clr) | short_set;
      open_load_flag_ff   <= (open_load_flag_ff & ~clr) | open_set;
      supply_fail_flag_ff <= (supply_fail_flag_ff & ~clr) | supply_set;
    end
  end

  wire temp_prewarn_flag = sns.temp_warn & ~stby_on;

  wire [W-1:0] status_word = {supply_fail_flag_ff, open_load_flag_ff, short_flag_ff,
                              {hbsc_pkg::ST_PAD_W{1'b0}}, sw_drive_ff, temp_prewarn_flag};

  // Transmit side
  logic [W-1:0] tx_sr_ff;
  logic         sdo_ff;
  logic         oe_ff;

  // First rising edge precedes the first sample, so shifting waits for one
  // falling edge; otherwise bit zero would never be seen by the host.
  wire tx_shift = sclk_rise & sel & (rx_cnt_ff != hbsc_pkg::CNT_ZERO);

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tx_sr_ff <= hbsc_pkg::WORD_ZERO;
      sdo_ff   <= 1'b0;
      oe_ff    <= 1'b0;
    end
    else if (mclk_en)
    begin
      if (cs_fall)
      begin
        tx_sr_ff <= status_word;
        sdo_ff   <= status_word[hbsc_pkg::ST_TEMP_BIT];
        oe_ff    <= 1'b1;
      end
      else if (cs_rise)
        oe_ff <= 1'b0;
      else if (tx_shift)
      begin
        tx_sr_ff <= {1'b0, tx_sr_ff[W-1:1]};
        sdo_ff   <= tx_sr_ff[1];
      end
    end
  end

  assign sdo_out                 = sdo_ff;
  assign sdo_oe                  = oe_ff;
  assign low_side_en_1           = sw_drive_ff[0];
  assign high_side_en_1          = sw_drive_ff[1];
  assign low_side_en_2           = sw_drive_ff[2];
  assign high_side_en_2          = sw_drive_ff[3];
  assign low_side_en_3           = sw_drive_ff[4];
  assign high_side_en_3          = sw_drive_ff[5];
  assign overcurrent_shutdown_en = ctrl_ff.shdn_en;

  // Checks
  a_oe_on_select: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && cs_fall) |=> (sdo_oe && sdo_out == $past(temp_prewarn_flag)))
    else $error("output not driven with prewarning at select");

  a_oe_off_deselect: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && cs_rise) |=> !sdo_oe)
    else $error("output still driven after deselect");

  a_rx_fall_sample: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && sclk_fall && sel) |=> (rx_sr_ff[W-1] == $past(sync2_ff.serial_in)))
    else $error("input bit not sampled on falling edge");

  a_tx_hold_stable: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && !tx_shift && !cs_fall) |=> $stable(sdo_out))
    else $error("output bit changed without rising edge");

  a_commit_on_rise: assert property (@(posedge mclk) disable iff (reset)
    (!stby_on && !(mclk_en && cs_rise && rx_full)) |=> $stable(pend_word_ff))
    else $error("control word captured outside chip select rise");

  a_abort_keeps_ctrl: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && cs_rise && !rx_full && !buf_out_valid && !pend_ff && !stby_on)
      |=> ##1 $stable(ctrl_ff))
    else $error("aborted frame altered control");

  a_clear_flags: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && clr && !short_set && !open_set && !supply_set && !stby_on)
      |=> (!short_flag_ff && !open_load_flag_ff && !supply_fail_flag_ff))
    else $error("status clear did not clear flags");

  a_short_sets: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && !stby_on && |oc_trip) |=> (short_flag_ff && (sw_drive_ff & $past(oc_trip)) == '0))
    else $error("short did not set flag and switch off");

  a_shdn_off_keeps: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && !stby_on && !ctrl_ff.shdn_en && !sns.undervolt)
      |=> (sw_drive_ff == $past(sw_cmd)))
    else $error("switch dropped with shutdown disabled");

  // Prewarning is a live level and may return as standby ends, so bit zero is left out
  a_standby_clears: assert property (@(posedge mclk) disable iff (reset)
    stby_on |=> (sw_drive_ff == '0 && status_word[W-1:hbsc_pkg::ST_SW_LSB] == '0
                 && ctrl_ff.shdn_en == hbsc_pkg::SHDN_RST))
    else $error("standby left switches or status set");

  a_status_layout: assert property (@(posedge mclk) disable iff (reset)
    (mclk_en && cs_fall) |=> ((tx_sr_ff[hbsc_pkg::ST_SW_LSB +: N] == $past(sw_drive_ff))
      && (tx_sr_ff[hbsc_pkg::ST_SW_LSB + N +: hbsc_pkg::ST_PAD_W] == '0)
      && (tx_sr_ff[hbsc_pkg::ST_SHORT_BIT] == $past(short_flag_ff))
      && (tx_sr_ff[hbsc_pkg::ST_OPEN_BIT] == $past(open_load_flag_ff))
      && (tx_sr_ff[hbsc_pkg::ST_SUPPLY_BIT] == $past(supply_fail_flag_ff))))
    else $error("status word layout wrong");

endmodule

/* src/hbsc_pkg.sv */
// Constants, field layout and carrier types for the half-bridge serial control block.
// Assumes every user file refers to these items by their scoped names.
package hbsc_pkg;

  // Word and field layout
  localparam int          WORD_W        = 16;
  localparam int          NUM_SW        = 6;
  localparam int          CNT_W         = 5;
  localparam int          CTRL_CLR_BIT  = 0;
  localparam int          CTRL_SW_LSB   = 1;
  localparam int          CTRL_SHDN_BIT = 13;
  localparam int          ST_TEMP_BIT   = 0;
  localparam int          ST_SW_LSB     = 1;
  localparam int          ST_PAD_W      = 6;
  localparam int          ST_SHORT_BIT  = 13;
  localparam int          ST_OPEN_BIT   = 14;
  localparam int          ST_SUPPLY_BIT = 15;
  localparam logic [4:0]  WORD_BITS     = 5'h10;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;
  localparam logic [4:0]  CNT_ONE       = 5'h01;

  // Buffer shape
  localparam int          BUF_DEPTH     = 2;

  // Reset values
  localparam logic        SHDN_RST      = 1'b1;
  localparam logic [5:0]  SW_RST        = 6'h00;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;

  // Applied control fields
  typedef struct packed {
    logic       shdn_en;
    logic [5:0] sw_en;
  } hbsc_ctrl_t;

  // Analog detector levels, one bit per switch where per switch
  typedef struct packed {
    logic       temp_warn;
    logic       undervolt;
    logic [5:0] overcurrent;
    logic [5:0] open_load;
  } hbsc_sense_t;

  // Every asynchronous input, synchronised as one group
  typedef struct packed {
    logic        cs_n;
    logic        sclk;
    logic        serial_in;
    logic        standby_ctrl_n;
    hbsc_sense_t sense;
  } hbsc_pins_t;

  localparam hbsc_pins_t PINS_RST = '{cs_n: 1'b1, sclk: 1'b0, serial_in: 1'b0,
                                      standby_ctrl_n: 1'b0, sense: '0};

endpackage

/* src/hbsc_word_buf.sv */
// Two-entry word buffer with valid/ready on both sides.
// Assumes a single clock, synchronous reset and a freeze enable shared with its user.
`timescale 1ns/10ps
module hbsc_word_buf #(
  parameter int W     = hbsc_pkg::WORD_W,
  parameter int DEPTH = hbsc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         mclk_en,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0]   count_ff;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count_ff != CNT_FULL);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else if (mclk_en)
    begin
      if (push)
      begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff         <= wr_ptr_ff + PW'(1);
      end
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

/* test/hbsc_host_model.sv */
// Host side of the serial link: chip select, serial clock and data, and the read-back line.
// Assumes mclk is only a timing reference; the 125 ns link clock is made here.
`timescale 1ns/10ps
module hbsc_host_model (
  // Timing reference
  input  wire logic mclk,
  // Serial pins
  output logic      cs_n,
  output logic      sclk,
  output logic      serial_in,
  input  wire logic sdo_out,
  input  wire logic sdo_oe
);
  localparam realtime HALF = 62.5;
  wire logic          sdo_line;

  // Released line floats, so a read while deselected never matches
  assign sdo_line = sdo_oe ? sdo_out : 1'bz;

  // Pulled-down clock and data stand low outside frames
  initial
  begin
    cs_n      = 1'b1;
    sclk      = 1'b0;
    serial_in = 1'b0;
  end

  task automatic xfer(input logic [15:0] ctrl, input int nbits, output logic [15:0] stat);
    stat = 16'h0000;
    @(posedge mclk);
    #1;
    cs_n = 1'b0;
    #HALF;
    stat[0] = sdo_line;
    for (int i = 0; i < nbits; i++)
    begin
      sclk      = 1'b1;
      serial_in = ctrl[i];
      #HALF;
      sclk    = 1'b0;
      stat[i] = sdo_line;
      #HALF;
    end
    cs_n      = 1'b1;
    serial_in = 1'b0;
    #HALF;
    // Hand back just after a clock edge so bench stimulus keeps its fixed offset
    @(posedge mclk);
    #1;
  endtask
endmodule

/* test/hbsc_serial_ctrl_tb.sv */
// Self-checking bench for the half-bridge serial control block.
// Assumes the host model drives the serial pins; the bench drives detectors and handshakes.
`timescale 1ns/10ps
module hbsc_serial_ctrl_tb;
  typedef struct packed {
    logic [15:0]           ctrl;
    hbsc_pkg::hbsc_sense_t sense;
    logic [5:0]            drive;
    logic                  shdn;
    logic [15:0]           stat;
  } hbsc_row_t;

  logic                  mclk;
  logic                  reset;
  logic                  mclk_en;
  logic                  standby_ctrl_n;
  logic                  apply_ready;
  hbsc_pkg::hbsc_sense_t sense;
  wire logic             cs_n;
  wire logic             sclk;
  wire logic             serial_in;
  wire logic             sdo_out;
  wire logic             sdo_oe;
  wire logic             ctrl_buf_ready;
  wire logic [5:0]       drive;
  wire logic             shdn_en;
  logic [15:0]           stat;
  int                    checks;
  int                    n_mismatch;

  // Written word, detector levels, expected drive, shutdown enable and status read next frame
  // last row fills unused bits with shutdown low, so no test pattern is sent
  hbsc_row_t rows [8] = '{
    '{16'h2002, 14'h0000, 6'h01, 1'b1, 16'h0002},
    '{16'h207E, 14'h2000, 6'h3F, 1'b1, 16'h007F},
    '{16'h0054, 14'h0080, 6'h2A, 1'b0, 16'h2054},
    '{16'h2001, 14'h0000, 6'h00, 1'b1, 16'h0000},
    '{16'h2006, 14'h0040, 6'h02, 1'b1, 16'h2004},
    '{16'h2007, 14'h0002, 6'h03, 1'b1, 16'h4006},
    '{16'h2003, 14'h1000, 6'h00, 1'b1, 16'h8000},
    '{16'hDFC0, 14'h0000, 6'h20, 1'b0, 16'h8040}
  };

  hbsc_serial_ctrl u_hbsc_serial_ctrl (
    .mclk                    (mclk),
    .reset                   (reset),
    .mclk_en                 (mclk_en),
    .cs_n                    (cs_n),
    .sclk                    (sclk),
    .serial_in               (serial_in),
    .sdo_out                 (sdo_out),
    .sdo_oe                  (sdo_oe),
    .standby_ctrl_n          (standby_ctrl_n),
    .sense                   (sense),
    .apply_ready             (apply_ready),
    .ctrl_buf_ready          (ctrl_buf_ready),
    .low_side_en_1           (drive[0]),
    .high_side_en_1          (drive[1]),
    .low_side_en_2           (drive[2]),
    .high_side_en_2          (drive[3]),
    .low_side_en_3           (drive[4]),
    .high_side_en_3          (drive[5]),
    .overcurrent_shutdown_en (shdn_en)
  );

  hbsc_host_model u_hbsc_host_model (
    .mclk      (mclk),
    .cs_n      (cs_n),
    .sclk      (sclk),
    .serial_in (serial_in),
    .sdo_out   (sdo_out),
    .sdo_oe    (sdo_oe)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_out(input logic [5:0] exp_drive, input logic exp_shdn);
    check("drive", {10'h000, exp_drive}, {10'h000, drive});
    check("shdn_en", {15'h0000, exp_shdn}, {15'h0000, shdn_en});
  endtask

  task automatic xfer(input logic [15:0] ctrl, input int nbits);
    u_hbsc_host_model.xfer(ctrl, nbits, stat);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // About 25 frames of 2.1 us each; generous margin
  initial
  begin
    #200000;
    n_mismatch++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end

  initial
  begin
    checks         = 0;
    n_mismatch     = 0;
    reset          = 1'b1;
    mclk_en        = 1'b1;
    standby_ctrl_n = 1'b1;
    apply_ready    = 1'b1;
    sense          = '0;
    cyc(6);
    reset = 1'b0;
    cyc(6);
    foreach (rows[i])
    begin
      xfer(rows[i].ctrl, 16);
      sense = rows[i].sense;
      cyc(20);
      chk_out(rows[i].drive, rows[i].shdn);
      xfer(rows[i].ctrl, 16);
      cyc(20);
      check("status", rows[i].stat, stat);
      sense = '0;
      cyc(10);
      $display("test row %0d done", i);
    end
    sense = 14'h2000;
    cyc(4);
    xfer(16'h207E, 0);
    check("prewarn", 16'h0001, {15'h0000, stat[0]});
    xfer(16'h207E, 5);
    cyc(20);
    chk_out(6'h20, 1'b0);
    xfer(16'hDFC0, 16);
    check("status", 16'h8041, stat);
    sense = '0;
    $display("test abort done");
    apply_ready = 1'b0;
    xfer(16'h2002, 16);
    xfer(16'h2008, 16);
    cyc(10);
    check("buf_ready", 16'h0000, {15'h0000, ctrl_buf_ready});
    chk_out(6'h20, 1'b0);
    xfer(16'h2020, 16);
    apply_ready = 1'b1;
    cyc(30);
    chk_out(6'h10, 1'b1);
    $display("test stall done");
    standby_ctrl_n = 1'b0;
    cyc(10);
    chk_out(6'h00, 1'b1);
    standby_ctrl_n = 1'b1;
    cyc(10);
    xfer(16'h2000, 16);
    check("status", 16'h0000, stat);
    check("sdo_oe", 16'h0000, {15'h0000, sdo_oe});
    $display("test standby done");
    xfer(16'h207E, 16);
    cyc(20);
    // Frozen clock enable: a standby pulse must not reach the state
    mclk_en        = 1'b0;
    standby_ctrl_n = 1'b0;
    cyc(10);
    chk_out(6'h3F, 1'b1);
    standby_ctrl_n = 1'b1;
    cyc(4);
    mclk_en = 1'b1;
    cyc(10);
    chk_out(6'h3F, 1'b1);
    $display("test freeze done");
    reset = 1'b1;
    cyc(6);
    chk_out(6'h00, 1'b1);
    check("buf_ready", 16'h0001, {15'h0000, ctrl_buf_ready});
    reset = 1'b0;
    cyc(6);
    $display("test reset done");
    summarize();
  end
endmodule
